// ==== hw/dskip_map.svh ====
`ifndef DSKIP_MAP_SVH
`define DSKIP_MAP_SVH

// instruction word fields
`define DS_OPC_HI      15
`define DS_OPC_LO      9
`define DS_OPC_DSZ     7'h0b
`define DS_OPC_DSNZ    7'h13
`define DS_GOTO_HI     15
`define DS_GOTO_LO     13
`define DS_OPC_GOTO    3'h6
`define DS_DIR_BIT     8
`define DS_ADDR_HI     7
`define DS_ADDR_LO     0
`define DS_K_HI        12
`define DS_K_LO        0
`define DS_K_UP_HI     12
`define DS_K_UP_LO     8
`define DS_PAGE_HI     15
`define DS_PAGE_LO     13

// destination select values of the direction bit
`define DS_DEST_WORKING_REGISTER   1'h0
`define DS_DEST_FILE   1'h1

// arithmetic constants
`define DS_ONE         8'h01
`define DS_ZERO        8'h00

// four-phase instruction cycle
`define DS_PH_Q1       2'h0
`define DS_PH_Q2       2'h1
`define DS_PH_Q3       2'h2
`define DS_PH_Q4       2'h3
`define DS_PH_STEP     2'h1

// reset values
`define DS_RST_BYTE    8'h00
`define DS_RST_WORD    16'h0000
`define DS_RST_PH      2'h0

`endif

// ==== hw/dskip_pkg.sv ====
package dskip_pkg;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_DSZ,
    OP_DSNZ,
    OP_GOTO
  } op_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_NOP
  } seq_state_t;

endpackage

// ==== hw/q_phase_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dskip_map.svh"

module q_phase_gen (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  output logic      [1:0] o_phase,
  output logic            o_q1,
  output logic            o_q2,
  output logic            o_q3,
  output logic            o_q4
);

  logic [1:0] phase_reg;
  logic [1:0] phase_next;

  assign phase_next = phase_reg + `DS_PH_STEP;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      phase_reg <= `DS_RST_PH;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign o_phase = phase_reg;
  assign o_q1    = (phase_reg == `DS_PH_Q1);
  assign o_q2    = (phase_reg == `DS_PH_Q2);
  assign o_q3    = (phase_reg == `DS_PH_Q3);
  assign o_q4    = (phase_reg == `DS_PH_Q4);

endmodule // q_phase_gen
`default_nettype wire

// ==== hw/dec_skip_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dskip_map.svh"

module dec_skip_unit
  import dskip_pkg::*;
(
  input  wire logic  [15:0] i_instr,
  input  wire logic  [7:0]  i_operand,
  output var op_kind_t      o_kind,
  output logic              o_dest_file,
  output logic       [7:0]  o_addr,
  output logic       [7:0]  o_result,
  output logic              o_skip
);

  wire [6:0] opc_hi   = i_instr[`DS_OPC_HI:`DS_OPC_LO];
  wire [2:0] opc_goto = i_instr[`DS_GOTO_HI:`DS_GOTO_LO];
  wire       is_dsz   = (opc_hi == `DS_OPC_DSZ);
  wire       is_dsnz  = (opc_hi == `DS_OPC_DSNZ);
  wire       is_goto  = (opc_goto == `DS_OPC_GOTO);
  wire       zero_res;

  assign o_kind = is_dsz  ? OP_DSZ  :
                  is_dsnz ? OP_DSNZ :
                  is_goto ? OP_GOTO : OP_NONE;

  assign o_dest_file = i_instr[`DS_DIR_BIT];               // [RULE4]
  assign o_addr      = i_instr[`DS_ADDR_HI:`DS_ADDR_LO];   // [RULE11]
  // 8-bit difference wraps 0x00 to 0xff by construction
  assign o_result    = i_operand - `DS_ONE;                // [RULE3] [RULE11]
  assign zero_res    = (o_result == `DS_ZERO);
  assign o_skip      = (is_dsz && zero_res)                // [RULE1] [RULE2]
                    || (is_dsnz && !zero_res);             // [RULE5]

endmodule // dec_skip_unit
`default_nettype wire

// ==== hw/dec_skip_goto_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dskip_map.svh"

// What this block does
// (RULE1) skip-on-zero: decrement, skip next when zero
// (RULE2) skip-on-zero nonzero result: run next instruction
// (RULE3) skip-on-nonzero: read, decrement, write destination
// (RULE4) direction 0 to working register, 1 file
// (RULE5) skip-on-nonzero: discard next when result nonzero
// (RULE6) taken skip adds one forced no-op cycle
// (RULE7) branch loads 13-bit target into pc 12:0
// (RULE8) pc upper eight bits copied into high latch
// (RULE9) branch always two cycles, second forced no-op
// (RULE10) branch target 0..8191 within current page
// (RULE11) decrement wraps mod 256, address low byte
module dec_skip_goto_exec
  import dskip_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_instr_valid,
  input  wire logic [15:0] i_instr,
  input  wire logic [15:0] i_pc,
  input  wire logic [7:0]  i_rf_rdata,
  output logic             o_ready,
  output logic             o_busy,
  output logic      [1:0]  o_phase,
  output logic             o_rf_re,
  output logic      [7:0]  o_rf_raddr,
  output logic             o_rf_we,
  output logic      [7:0]  o_rf_waddr,
  output logic      [7:0]  o_rf_wdata,
  output logic             o_working_register_we,
  output logic      [7:0]  o_working_register_data,
  output logic             o_pc_we,
  output logic      [15:0] o_pc_data,
  output logic             o_pc_high_latch_we,
  output logic      [7:0]  o_pc_high_latch_data,
  output logic             o_discard,
  output logic             o_forced_nop
);

  // phase timing
  logic       q1;
  logic       q2;
  logic       q3;
  logic       q4;
  logic [1:0] phase;

  q_phase_gen u_phase (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .o_phase (phase),
    .o_q1    (q1),
    .o_q2    (q2),
    .o_q3    (q3),
    .o_q4    (q4)
  );

  assign o_phase = phase;

  // sequencer state
  seq_state_t  state_reg;
  seq_state_t  state_next;
  logic [15:0] instr_reg;
  logic [7:0]  operand_reg;
  logic [15:0] page_pc_reg;

  // decode of the incoming word, used to claim it and to set the read request and address
  op_kind_t    in_kind;
  logic        in_dest;
  logic [7:0]  in_addr;
  logic [7:0]  in_result;
  logic        in_skip;

  dec_skip_unit u_in_dec (
    .i_instr     (i_instr),
    .i_operand   (`DS_ZERO),
    .o_kind      (in_kind),
    .o_dest_file (in_dest),
    .o_addr      (in_addr),
    .o_result    (in_result),
    .o_skip      (in_skip)
  );

  // decode and decrement of the held word
  op_kind_t    ex_kind;
  logic        ex_dest_file;
  logic [7:0]  ex_addr;
  logic [7:0]  ex_result;
  logic        ex_skip;

  dec_skip_unit u_ex_dec (
    .i_instr     (instr_reg),
    .i_operand   (operand_reg),
    .o_kind      (ex_kind),
    .o_dest_file (ex_dest_file),
    .o_addr      (ex_addr),
    .o_result    (ex_result),
    .o_skip      (ex_skip)
  );

  // decode and selection
  wire in_claim    = (in_kind != OP_NONE);
  wire take        = q1 && (state_reg == ST_IDLE) && i_instr_valid && in_claim;
  wire ex_is_goto  = (ex_kind == OP_GOTO);
  wire ex_is_dec   = (ex_kind == OP_DSZ) || (ex_kind == OP_DSNZ);
  wire exec_q2     = (state_reg == ST_EXEC) && q2;
  wire exec_q3     = (state_reg == ST_EXEC) && q3;
  wire exec_q4     = (state_reg == ST_EXEC) && q4;
  wire nop_q4      = (state_reg == ST_NOP) && q4;
  // a branch always flushes; a decrement only when its test fires
  wire need_nop    = ex_is_goto || (ex_is_dec && ex_skip);           // [RULE6] [RULE9]
  wire wr_file     = ex_is_dec && (ex_dest_file == `DS_DEST_FILE);    // [RULE4]
  wire wr_working_register     = ex_is_dec && (ex_dest_file == `DS_DEST_WORKING_REGISTER);    // [RULE4]

  // branch target: only bits 12:0 replaced, page bits kept
  wire [12:0] k_val      = instr_reg[`DS_K_HI:`DS_K_LO];             // [RULE10]
  wire [2:0]  page_bits  = page_pc_reg[`DS_PAGE_HI:`DS_PAGE_LO];
  wire [15:0] goto_pc    = {page_bits, k_val};                       // [RULE7]
  wire [7:0]  goto_lath  = {page_bits,                               // [RULE8]
                            goto_pc[`DS_K_UP_HI:`DS_K_UP_LO]};

  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (q4) begin
          state_next = need_nop ? ST_NOP : ST_IDLE;                 // [RULE6] [RULE9]
        end
      end
      ST_NOP: begin
        if (q4) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // capture word and page at decode
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      instr_reg   <= `DS_RST_WORD;
      page_pc_reg <= `DS_RST_WORD;
    end else if (take) begin
      instr_reg   <= i_instr;
      page_pc_reg <= i_pc;
    end
  end

  // operand sampled at the end of the read phase
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      operand_reg <= `DS_RST_BYTE;
    end else if (exec_q2 && ex_is_dec) begin
      operand_reg <= i_rf_rdata;                                     // [RULE3]
    end
  end

  // register file read request during the read phase
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rf_re    <= 1'b0;
      o_rf_raddr <= `DS_RST_BYTE;
    end else begin
      o_rf_re    <= take && (in_kind != OP_GOTO);
      if (take) begin
        o_rf_raddr <= in_addr;                                       // [RULE11]
      end
    end
  end

  // destination writes land in q4
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rf_we    <= 1'b0;
      o_rf_waddr <= `DS_RST_BYTE;
      o_rf_wdata <= `DS_RST_BYTE;
    end else begin
      o_rf_we <= exec_q3 && wr_file;                                 // [RULE4]
      if (exec_q3 && wr_file) begin
        o_rf_waddr <= ex_addr;
        o_rf_wdata <= ex_result;                                     // [RULE3]
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_working_register_we   <= 1'b0;
      o_working_register_data <= `DS_RST_BYTE;
    end else begin
      o_working_register_we <= exec_q3 && wr_working_register;                               // [RULE4]
      if (exec_q3 && wr_working_register) begin
        o_working_register_data <= ex_result;                                    // [RULE3]
      end
    end
  end

  // branch updates pc and its high latch together
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_pc_we       <= 1'b0;
      o_pc_data     <= `DS_RST_WORD;
      o_pc_high_latch_we   <= 1'b0;
      o_pc_high_latch_data <= `DS_RST_BYTE;
    end else begin
      o_pc_we     <= exec_q3 && ex_is_goto;                          // [RULE7]
      o_pc_high_latch_we <= exec_q3 && ex_is_goto;                          // [RULE8]
      if (exec_q3 && ex_is_goto) begin
        o_pc_data     <= goto_pc;                                    // [RULE7] [RULE10]
        o_pc_high_latch_data <= goto_lath;                                  // [RULE8]
      end
    end
  end

  // discard tells the fetch stage to drop the prefetched word
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_discard <= 1'b0;
    end else begin
      o_discard <= exec_q3 && need_nop;                              // [RULE1] [RULE5] [RULE9]
    end
  end

  // forced no-op spans one whole instruction cycle
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_forced_nop <= 1'b0;
    end else if (exec_q4 && need_nop) begin
      o_forced_nop <= 1'b1;                                          // [RULE6] [RULE9]
    end else if (nop_q4) begin
      o_forced_nop <= 1'b0;
    end
  end

  // status toward the fetch stage
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_busy  <= 1'b0;
      o_ready <= 1'b1;
    end else begin
      o_busy  <= (state_next != ST_IDLE);
      o_ready <= (state_next == ST_IDLE);                            // [RULE2]
    end
  end

endmodule // dec_skip_goto_exec
`default_nettype wire

// ==== verif/dskip_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module dskip_chk (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [15:0] i_pc,
  input wire logic [7:0]  i_rf_rdata,
  input wire logic        o_ready,
  input wire logic        o_busy,
  input wire logic [1:0]  o_phase,
  input wire logic        o_rf_re,
  input wire logic [7:0]  o_rf_raddr,
  input wire logic        o_rf_we,
  input wire logic [7:0]  o_rf_wdata,
  input wire logic        o_working_register_we,
  input wire logic [7:0]  o_working_register_data,
  input wire logic        o_pc_we,
  input wire logic [15:0] o_pc_data,
  input wire logic        o_pc_high_latch_we,
  input wire logic [7:0]  o_pc_high_latch_data,
  input wire logic        o_discard,
  input wire logic        o_forced_nop
);
  wire logic take  = o_phase == 2'h0 && o_ready && i_instr_valid;
  wire logic t_sz  = take && i_instr[15:9] == 7'h0b;
  wire logic t_snz = take && i_instr[15:9] == 7'h13;
  wire logic t_dec = t_sz || t_snz;
  wire logic t_br  = take && i_instr[15:13] == 3'h6;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  property p_rd; t_dec |=> o_rf_re && o_rf_raddr == $past(i_instr[7:0]); endproperty
  a_rd: assert property (p_rd) else $error("register read wrong");
  property p_dstf; t_dec && i_instr[8] |-> ##3 o_rf_we && !o_working_register_we; endproperty
  a_dstf: assert property (p_dstf) else $error("file write missing");
  property p_dstw; t_dec && !i_instr[8] |-> ##3 o_working_register_we && !o_rf_we; endproperty
  a_dstw: assert property (p_dstw) else $error("working write missing");
  property p_res;
    (o_rf_we || o_working_register_we) |-> (o_rf_we ? o_rf_wdata : o_working_register_data) == 8'($past(i_rf_rdata, 2) - 8'h01);
  endproperty
  a_res: assert property (p_res) else $error("decrement result wrong");
  property p_sz; t_sz |-> ##3 o_discard == ($past(i_rf_rdata, 2) == 8'h01); endproperty
  a_sz: assert property (p_sz) else $error("zero skip wrong");
  property p_snz; t_snz |-> ##3 o_discard == ($past(i_rf_rdata, 2) != 8'h01); endproperty
  a_snz: assert property (p_snz) else $error("nonzero skip wrong");
  property p_nop; o_discard |=> o_forced_nop [*4] ##1 !o_forced_nop; endproperty
  a_nop: assert property (p_nop) else $error("forced no-op length wrong");
  property p_two; t_dec |-> ##4 o_ready != $past(o_discard); endproperty
  a_two: assert property (p_two) else $error("cycle count wrong");
  property p_br;
    t_br |-> ##3 o_pc_we && o_discard && o_pc_data == {$past(i_pc[15:13], 3), $past(i_instr[12:0], 3)};
  endproperty
  a_br: assert property (p_br) else $error("branch target wrong");
  property p_lat; o_pc_we |-> o_pc_high_latch_we && o_pc_high_latch_data == o_pc_data[15:8]; endproperty
  a_lat: assert property (p_lat) else $error("latch copy wrong");
  c_skip: cover property (o_discard && o_rf_we);
  c_working_register: cover property (o_working_register_we && !o_discard);
  c_br: cover property (o_pc_we);
endmodule // dskip_chk
bind dec_skip_goto_exec dskip_chk dskip_chk_i (.*);
`default_nettype wire

// ==== verif/rf_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rf_model (
  input  wire logic       i_clk,
  input  wire logic       i_re,
  input  wire logic [7:0] i_raddr,
  input  wire logic       i_we,
  input  wire logic [7:0] i_waddr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem [256];
  // bus not held outside a read: inverse exposes a late sample
  assign o_rdata = i_re ? mem[i_raddr] : ~mem[i_raddr];
  always @(posedge i_clk) if (i_we) mem[i_waddr] <= i_wdata;
endmodule // rf_model
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [15:0] ins; logic [15:0] pc; logic [7:0] rd; logic [15:0] ex; logic sk;} row_t;
  logic i_clk, i_reset, i_instr_valid, o_ready, o_busy, o_rf_re, o_rf_we, o_working_register_we;
  logic o_pc_we, o_pc_high_latch_we, o_discard, o_forced_nop;
  logic [15:0] i_instr, i_pc, o_pc_data;
  logic [7:0]  i_rf_rdata, o_rf_raddr, o_rf_waddr, o_rf_wdata, o_working_register_data, o_pc_high_latch_data;
  logic [1:0]  o_phase;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  row_t rows [8] = '{
    '{16'h1712, 16'h0000, 8'h01, 16'h0000, 1'b1}, '{16'h1634, 16'h0000, 8'h05, 16'h0004, 1'b0},
    '{16'h17ff, 16'h0000, 8'h00, 16'h00ff, 1'b0}, '{16'h2700, 16'h0000, 8'h01, 16'h0000, 1'b0},
    '{16'h2680, 16'h0000, 8'h00, 16'h00ff, 1'b1}, '{16'hdabc, 16'he000, 8'h00, 16'hfabc, 1'b1},
    '{16'hc000, 16'h2000, 8'h00, 16'h2000, 1'b1}, '{16'hdfff, 16'h0000, 8'h00, 16'h1fff, 1'b1}};
  dec_skip_goto_exec dec_skip_goto_exec_i (.*);
  rf_model rf_model_i (.i_clk(i_clk), .i_re(o_rf_re), .i_raddr(o_rf_raddr), .i_we(o_rf_we),
    .i_waddr(o_rf_waddr), .i_wdata(o_rf_wdata), .o_rdata(i_rf_rdata));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // waits for an idle Q1, offers one word, returns at the Q4 cycle
  task automatic go(input logic [15:0] ins, input logic [15:0] pc);
    int n;
    for (n = 0; n < 40 && !(o_phase === 2'h0 && o_ready === 1'b1); n++) @(negedge i_clk);
    if (n == 40) begin
      miscompares++;
      $display("unexpected at %0t: block never returned to idle", $time);
    end
    i_instr_valid = 1'b1;
    i_instr = ins;
    i_pc = pc;
    @(negedge i_clk);
    i_instr_valid = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    i_reset = 1'b1;
    i_instr_valid = 1'b0;
    i_instr = 16'h0000;
    i_pc = 16'h0000;
    repeat (16) @(negedge i_clk);
    chk({o_ready, o_busy, o_forced_nop, o_rf_we}, 4'h8);
    $display("reset done");
    i_reset = 1'b0;
    foreach (rows[i]) begin
      rf_model_i.mem[rows[i].ins[7:0]] = rows[i].rd;
      go(rows[i].ins, rows[i].pc);
      if (rows[i].ins[15:13] == 3'h6) begin
        chk({o_pc_we, o_pc_high_latch_we, o_discard, o_busy, 4'h0, o_pc_high_latch_data}, {8'hf0, rows[i].ex[15:8]});
        chk(o_pc_data, rows[i].ex);
      end else begin
        chk({o_rf_we, o_working_register_we, o_discard, o_busy, 4'h0, rows[i].ins[8] ? o_rf_wdata : o_working_register_data},
          {rows[i].ins[8], ~rows[i].ins[8], rows[i].sk, 1'b1, 4'h0, rows[i].ex[7:0]});
      end
      @(negedge i_clk);
      chk({15'h0, o_forced_nop}, {15'h0, rows[i].sk});
      if (rows[i].ins[15:13] != 3'h6 && rows[i].ins[8]) begin
        chk({8'h0, rf_model_i.mem[rows[i].ins[7:0]]}, {8'h0, rows[i].ex[7:0]});
      end
      $display("row %0d done", i);
    end
    // unmatched opcode must leave the block idle
    go(16'h0712, 16'h0000);
    chk({o_busy, o_rf_we, o_working_register_we, o_discard}, 4'h0);
    $display("refused opcode done");
    // reset in mid-branch cancels the pending forced no-op
    go(16'hdabc, 16'he000);
    i_reset = 1'b1;
    @(negedge i_clk);
    i_reset = 1'b0;
    chk({o_ready, o_busy, o_pc_we, o_forced_nop}, 4'h8);
    // working-register destination left the cell at 0x05, so the result is 0x04
    go(16'h1634, 16'h0000);
    chk({o_working_register_we, o_discard, o_working_register_data}, {2'h2, 8'h04});
    $display("mid reset done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
